//--- src/baud_buf_pkg.sv
package baud_buf_pkg;

  // ----------------------------------------
  // Register byte addresses (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] data_buffer_addr = 8'h00;
  localparam logic [7:0] divisor_addr = 8'h04;
  localparam logic [7:0] control_two_addr = 8'h08;
  localparam logic [7:0] rx_data_addr = 8'h0c;
  localparam logic [7:0] status_addr = 8'h10;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int high_speed_bit = 5;
  localparam int prescale_tick_bit = 0;
  localparam logic [7:0] control_two_reset = 8'h00;
  localparam logic [7:0] divisor_reset = 8'h00;
  localparam logic [7:0] buffer_reset = 8'h00;
  localparam logic [5:0] prescale_low_last = 6'h3f;
  localparam logic [5:0] prescale_high_last = 6'h0f;
  localparam logic [14:0] tick_gap_longest = 15'h3fff; // 64 x 256 clocks, minus one
  localparam logic [14:0] tick_gap_shortest = 15'h000f; // 16 clocks, minus one

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] tx_byte_q;
    logic [7:0] rx_byte_q;
    logic [7:0] divisor_q;
    logic [7:0] control_two_q;
    logic [5:0] prescale_q;
    logic [7:0] timer_q;
    logic tick_q;
    logic tx_pending_q;
    logic rx_ready_q;
    logic [7:0] rdata_q;
  } state_t;

endpackage

//--- src/baud_buf.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module baud_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire baud_buf_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Shifter side
  output logic bit_tick,
  output logic high_speed,
  output logic [7:0] tx_byte,
  output logic tx_pending,
  input wire logic tx_take,
  input wire logic [7:0] rx_byte,
  input wire logic rx_load
);

  baud_buf_pkg::state_t s_q;
  baud_buf_pkg::state_t s_d;

  // Prescale last count for the selected speed
  function automatic logic [5:0] prescale_last(input logic hs);
    prescale_last = hs ? baud_buf_pkg::prescale_high_last : baud_buf_pkg::prescale_low_last;
  endfunction

  // Register port addresses one register
  function automatic logic addr_hit(input baud_buf_pkg::reg_req_t r, input logic [7:0] a);
    addr_hit = (r.addr == a);
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic pre_done;
    pre_done = 1'b0;
    s_d = s_q;
    s_d.tick_q = 1'b0;
    // Prescaler of 16 or 64 clocks
    pre_done = (s_q.prescale_q >= prescale_last(s_q.control_two_q[baud_buf_pkg::high_speed_bit]));
    s_d.prescale_q = pre_done ? 6'h00 : s_q.prescale_q + 6'h01;
    // Reloading 8-bit timer, one tick per divisor plus one prescaled periods
    if (pre_done) begin
      if (s_q.timer_q == 8'h00) begin
        s_d.timer_q = s_q.divisor_q;
        s_d.tick_q = 1'b1;
      end else begin
        s_d.timer_q = s_q.timer_q - 8'h01;
      end
    end
    // Shifter handshakes; load sets over software clear
    if (tx_take) begin
      s_d.tx_pending_q = 1'b0;
    end
    if (req.rd && addr_hit(req, baud_buf_pkg::data_buffer_addr)) begin
      s_d.rx_ready_q = 1'b0;
    end
    if (rx_load) begin
      s_d.rx_byte_q = rx_byte;
      s_d.rx_ready_q = 1'b1;
    end
    // Register writes
    if (req.wr) begin
      unique case (req.addr)
        baud_buf_pkg::data_buffer_addr: begin
          s_d.tx_byte_q = req.wdata;
          s_d.tx_pending_q = 1'b1;
        end
        baud_buf_pkg::divisor_addr: s_d.divisor_q = req.wdata;
        baud_buf_pkg::control_two_addr: s_d.control_two_q = req.wdata;
        default: ;
      endcase
    end
    // Read data, one cycle later
    s_d.rdata_q = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        baud_buf_pkg::data_buffer_addr: s_d.rdata_q = s_q.rx_byte_q;
        baud_buf_pkg::divisor_addr: s_d.rdata_q = s_q.divisor_q;
        baud_buf_pkg::control_two_addr: s_d.rdata_q = s_q.control_two_q;
        baud_buf_pkg::rx_data_addr: s_d.rdata_q = s_q.tx_byte_q;
        baud_buf_pkg::status_addr: s_d.rdata_q = {6'h00, s_q.rx_ready_q, s_q.tx_pending_q};
        default: s_d.rdata_q = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{tx_byte_q: baud_buf_pkg::buffer_reset,
               rx_byte_q: baud_buf_pkg::buffer_reset,
               divisor_q: baud_buf_pkg::divisor_reset,
               control_two_q: baud_buf_pkg::control_two_reset,
               prescale_q: 6'h00,
               timer_q: 8'h00,
               tick_q: 1'b0,
               tx_pending_q: 1'b0,
               rx_ready_q: 1'b0,
               rdata_q: 8'h00};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // One tick drives both directions
  assign bit_tick = s_q.tick_q;
  assign high_speed = s_q.control_two_q[baud_buf_pkg::high_speed_bit];
  assign tx_byte = s_q.tx_byte_q;
  assign tx_pending = s_q.tx_pending_q;
  assign rdata = s_q.rdata_q;

  // ----------------------------------------
  // Rate checks
  // ----------------------------------------
  // Enabled cycles since the last bit tick
  logic [14:0] gap_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_q <= 15'h0000;
    end else if (clk_en) begin
      gap_q <= s_d.tick_q ? 15'h0000 : gap_q + 15'h0001;
    end
  end

  // Slowest rate, 64 times 256 clocks apart
  a_tick_gap_max: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en |-> gap_q <= baud_buf_pkg::tick_gap_longest)
    else $error("bit tick gap too long");

  // Fastest rate, 16 clocks apart, also across speed changes
  a_tick_gap_min: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(bit_tick) |-> $past(gap_q) >= baud_buf_pkg::tick_gap_shortest)
    else $error("bit tick gap too short");

  // One pulse, never held by the timer
  a_tick_single_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    bit_tick && clk_en |=> !bit_tick)
    else $error("bit tick longer than one cycle");

  // Low speed prescaler wraps after 64 clocks
  a_prescale_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && s_q.prescale_q == baud_buf_pkg::prescale_low_last |=> s_q.prescale_q == 6'h00)
    else $error("prescaler did not wrap");

  // High speed prescaler wraps after 16 clocks
  a_prescale_high_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && high_speed && s_q.prescale_q == baud_buf_pkg::prescale_high_last |=>
    s_q.prescale_q == 6'h00)
    else $error("high speed prescaler did not wrap");

  // Prescaler drops into the short range once high speed settles
  a_high_prescale: assert property (@(posedge clk) disable iff (sys_rst)
    high_speed && $stable(high_speed) && $past(clk_en) |->
    s_q.prescale_q <= baud_buf_pkg::prescale_high_last)
    else $error("high speed prescaler over 16");

  // Each tick reloads the timer with the divisor
  a_tick_reload: assert property (@(posedge clk) disable iff (sys_rst)
    bit_tick |-> s_q.timer_q == s_q.divisor_q ||
    $past(req.wr && addr_hit(req, baud_buf_pkg::divisor_addr)))
    else $error("timer not reloaded with divisor");

  // ----------------------------------------
  // Register and handshake checks
  // ----------------------------------------
  // Buffer write lands in the transmit byte
  a_buffer_write: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && req.wr && req.addr == baud_buf_pkg::data_buffer_addr |=> tx_byte == $past(req.wdata))
    else $error("data buffer write lost");

  // Buffer write raises pending, even against a take
  a_tx_pending_set: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && req.wr && addr_hit(req, baud_buf_pkg::data_buffer_addr) |=> tx_pending)
    else $error("transmit pending not raised");

  // Take clears pending when no write competes
  a_tx_take_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && tx_take && !(req.wr && addr_hit(req, baud_buf_pkg::data_buffer_addr)) |=>
    !tx_pending)
    else $error("transmit pending not cleared");

  // Divisor write lands whole
  a_divisor_write: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && req.wr && addr_hit(req, baud_buf_pkg::divisor_addr) |=>
    s_q.divisor_q == $past(req.wdata))
    else $error("divisor write lost");

  // Speed select follows bit 5 of control register two
  a_speed_write: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && req.wr && req.addr == baud_buf_pkg::control_two_addr |=>
    high_speed == $past(req.wdata[baud_buf_pkg::high_speed_bit]))
    else $error("speed select not at bit 5");

  // Received byte and ready flag stored on a load
  a_rx_load_store: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && rx_load |=> s_q.rx_ready_q && s_q.rx_byte_q == $past(rx_byte))
    else $error("received byte not stored");

  // Buffer read clears ready unless a load competes
  a_rx_clear: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && req.rd && addr_hit(req, baud_buf_pkg::data_buffer_addr) && !rx_load |=>
    !s_q.rx_ready_q)
    else $error("receive ready not cleared");

  // Buffer read returns the received byte
  a_rx_read: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && req.rd && req.addr == baud_buf_pkg::data_buffer_addr |=>
    rdata == $past(s_q.rx_byte_q))
    else $error("received byte not returned");

  // Read data stand for one cycle only
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en && !req.rd |=> rdata == 8'h00)
    else $error("read data outside read cycle");

  // Clock enable low freezes every register
  a_freeze_state: assert property (@(posedge clk) disable iff (sys_rst)
    !clk_en |=> s_q == $past(s_q))
    else $error("state changed while frozen");

endmodule

//--- dv/shifter_model.sv
`timescale 1ns/1ns
module shifter_model (
  // Clock
  input wire logic clk,
  // Buffer side
  input wire logic tx_pending,
  output logic tx_take,
  output logic [7:0] rx_byte,
  output logic rx_load,
  // Bench control
  input wire logic rx_go,
  input wire logic [7:0] rx_val
);
  initial {tx_take, rx_byte, rx_load} = '0;
  // Take each pending byte once, load received bytes on command
  always @(posedge clk) begin
    tx_take <= tx_pending & ~tx_take;
    rx_load <= rx_go;
    rx_byte <= rx_go ? rx_val : ~rx_byte; // Not held outside a load
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, sys_rst = 1, clk_en = 1, rx_go = 0;
  baud_buf_pkg::reg_req_t req = '0;
  logic [7:0] rdata, tx_byte, rx_byte, d, rx_val = 8'h00;
  logic bit_tick, high_speed, tx_pending, tx_take, rx_load;
  int fail_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  baud_buf baud_buf_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
    .rdata(rdata), .bit_tick(bit_tick), .high_speed(high_speed), .tx_byte(tx_byte),
    .tx_pending(tx_pending), .tx_take(tx_take), .rx_byte(rx_byte), .rx_load(rx_load));
  shifter_model shifter_model_i (.clk(clk), .tx_pending(tx_pending), .tx_take(tx_take),
    .rx_byte(rx_byte), .rx_load(rx_load), .rx_go(rx_go), .rx_val(rx_val));
  // ----------------------------------------
  // Compare, bus and closing tasks
  // ----------------------------------------
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cmp_n(string what, int exp, int got);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %s exp %0d got %0d", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk) req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    @(negedge clk) v = rdata;
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values;
    rd(baud_buf_pkg::control_two_addr, d);
    cmp("control_two", 8'h00, d);
    rd(baud_buf_pkg::divisor_addr, d);
    cmp("divisor", 8'h00, d);
  endtask
  // Tick spacing in clock cycles, measured after two reloads
  task automatic rate(logic [7:0] n, logic hs, int exp);
    int c;
    wr(baud_buf_pkg::divisor_addr, n);
    wr(baud_buf_pkg::control_two_addr, {2'b00, hs, 5'h00});
    repeat (3) begin
      c = 0;
      do begin @(negedge clk); c++; end while (bit_tick !== 1'b1 && c < 20000);
    end
    cmp_n("tick_period", exp, c);
    cmp("high_speed", {7'h00, hs}, {7'h00, high_speed});
  endtask
  // Clock enable low for ten edges stretches a 16 clock period by ten
  task automatic freeze;
    int c;
    wr(baud_buf_pkg::divisor_addr, 8'h00);
    wr(baud_buf_pkg::control_two_addr, 8'h20);
    repeat (2) begin
      c = 0;
      do begin @(negedge clk); c++; end while (bit_tick !== 1'b1 && c < 20000);
    end
    c = 0;
    do begin
      @(posedge clk) clk_en <= !(c >= 1 && c < 11);
      @(negedge clk);
      c++;
    end while (bit_tick !== 1'b1 && c < 200);
    cmp_n("frozen_period", 16 + 10, c);
  endtask
  task automatic data_buffer;
    wr(baud_buf_pkg::data_buffer_addr, 8'ha5);
    @(negedge clk);
    cmp("tx_byte", 8'ha5, tx_byte);
    cmp("tx_pending", 8'h01, {7'h00, tx_pending});
    rd(baud_buf_pkg::rx_data_addr, d);
    cmp("tx_readback", 8'ha5, d);
    @(posedge clk) begin rx_val <= 8'h3c; rx_go <= 1'b1; end
    @(posedge clk) rx_go <= 1'b0;
    rd(baud_buf_pkg::status_addr, d);
    cmp("status", 8'h02, d);
    rd(baud_buf_pkg::data_buffer_addr, d);
    cmp("rx_data", 8'h3c, d);
    rd(baud_buf_pkg::status_addr, d);
    cmp("status_clear", 8'h00, d);
    rd(8'h14, d);
    cmp("unmapped", 8'h00, d);
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    reset_values();
    rate(8'h00, 1'b0, 64);
    rate(8'h01, 1'b0, 128);
    rate(8'h00, 1'b1, 16);
    freeze();
    rate(8'h02, 1'b1, 48);
    rate(8'hff, 1'b1, 4096);
    data_buffer();
    end_of_test();
  end
  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule
